// file: common/hps_regs.svh
// register map, field positions, reset values and timing counts of the host port
// Functional notes
// - write data is captured into the addressed register when write strobe or select rises
// - address latch follows address while latch enable is high, holds while low
// - the active-low reset input resets every register except the fifo storage asynchronously
// - with receiver enabled, interrupt rises when programmed byte count has arrived
// - interrupt rises at once on overrun, end of message, abort, ones-to-flags
// - a data read that empties the fifo clears the interrupt, otherwise it stays
// - overrun interrupt survives data reads; only a status read, receiver disable, internal receiver off or terminate bit clears it
// - receiver disable, internal receiver off or terminate bit force interrupt low
// - masking forces output low but the latch stays and remains readable
// - end flag rises on overrun or when an event-tagged byte is read
// - end flag falls on status read or receiver disable
// - underrun rises when a transmit data request is not answered in time
// - shared transmit request pin leaves reset as an input
// - data bus is driven only while read strobe and chip select are both low
`ifndef HPS_REGS_SVH
`define HPS_REGS_SVH
`define HPS_ADDR_RX_CFG 8'h00
`define HPS_ADDR_RX_IRQ 8'h01
`define HPS_ADDR_RX_STATUS 8'h02
`define HPS_ADDR_RX_DATA 8'h03
`define HPS_ADDR_DL_CFG 8'h04
`define HPS_ADDR_TX_DATA 8'h05
`define HPS_BIT_RX_EN 0
`define HPS_BIT_RX_TERM 1
`define HPS_BIT_IRQ_EN 7
`define HPS_BIT_IRQ_LATCH 6
`define HPS_LSB_IRQ_THR 0
`define HPS_MSB_IRQ_THR 3
`define HPS_BIT_DL_RX_ON 0
`define HPS_BIT_DL_PIN_OUT 1
`define HPS_RST_RX_CFG 8'h00
`define HPS_RST_RX_IRQ 8'h01
`define HPS_RST_DL_CFG 8'h00
`define HPS_TDL_TIMEOUT_PERIODS 3'h4
`define HPS_FIFO_AW 4
`define HPS_FIFO_W 10
`endif

// file: common/hps_pkg.sv
// types shared by the host port design
package hps_pkg;
   typedef logic [7:0] hps_byte_t;
   // tag stored with each received byte
   typedef enum logic [1:0] {
      HPS_TAG_DATA = 2'h0,
      HPS_TAG_EOM = 2'h1,
      HPS_TAG_ABORT = 2'h2,
      HPS_TAG_FLAGS = 2'h3
   } hps_tag_t;
   typedef enum logic [2:0] {
      HPS_ACC_IDLE = 3'h1,
      HPS_ACC_READ = 3'h2,
      HPS_ACC_WRITE = 3'h4
   } hps_acc_t;
endpackage

// file: logic/hps_fifo_mem.sv
// receive fifo storage with registered read data
`timescale 1ns/1ps
`include "hps_regs.svh"
module hps_fifo_mem (
   input wire logic clk_sys_in,
   input wire logic wr_en_in,
   input wire logic [`HPS_FIFO_AW-1:0] wr_addr_in,
   input wire logic [`HPS_FIFO_W-1:0] wr_data_in,
   input wire logic [`HPS_FIFO_AW-1:0] rd_addr_in,
   output logic [`HPS_FIFO_W-1:0] rd_data_out
);
   logic [`HPS_FIFO_W-1:0] mem [0:(1<<`HPS_FIFO_AW)-1];
   // no reset on storage; only pointers carry meaning
   always_ff @(posedge clk_sys_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
   end
endmodule

// file: logic/hps_host_port.sv
// host register port, receive link interrupt and end flag, transmit underrun
`timescale 1ns/1ps
`include "hps_regs.svh"
module hps_host_port (
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic write_strobe_n_in,
   input wire logic read_strobe_n_in,
   input wire logic chip_select_n_in,
   input wire logic ale_in,
   input wire logic [7:0] addr_in,
   input wire hps_pkg::hps_byte_t data_in,
   output hps_pkg::hps_byte_t data_out,
   output logic data_oe_out,
   input wire logic rx_byte_valid_in,
   input wire hps_pkg::hps_byte_t rx_byte_in,
   input wire hps_pkg::hps_tag_t rx_byte_tag_in,
   input wire logic tx_byte_taken_in,
   input wire logic tx_link_clock_in,
   input wire logic tx_link_serial_in_in,
   output logic tx_link_serial_in_out,
   output logic tx_link_data_request_out,
   output logic tx_link_pin_out,
   output logic tx_link_pin_oe_out,
   output hps_pkg::hps_byte_t tx_data_out,
   output logic tx_data_valid_out,
   output logic rx_link_irq_out,
   output logic rx_link_end_flag_out,
   output logic tx_link_underrun_out
);
   import hps_pkg::*;

   // two-stage synchronisers for the bus pins, the link clock and the shared pin
   localparam int SW = 22;
   logic [SW-1:0] pin_raw, pin_s1, pin_s2;
   assign pin_raw = {write_strobe_n_in, read_strobe_n_in, chip_select_n_in, ale_in,
                     tx_link_clock_in, tx_link_serial_in_in, addr_in, data_in};
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      // link clock idles low so no false edge follows reset; shared pin idles high
      if (!rstn_in) begin
         pin_s1 <= {4'hf, 2'h1, 16'h0000};
         pin_s2 <= {4'hf, 2'h1, 16'h0000};
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
      end
   end
   logic wr_n, rd_n, cs_n, ale, tclk;
   logic [7:0] addr_s;
   hps_byte_t dat_s;
   assign wr_n = pin_s2[21];
   assign rd_n = pin_s2[20];
   assign cs_n = pin_s2[19];
   assign ale = pin_s2[18];
   assign tclk = pin_s2[17];
   assign addr_s = pin_s2[15:8];
   assign dat_s = pin_s2[7:0];

   logic [7:0] addr_lat;
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         addr_lat <= 8'h00;
      end else if (ale) begin
         addr_lat <= addr_s;
      end
   end

   // access tracker: strobes combine with select, so a high select blocks all
   hps_acc_t acc, next_acc;
   logic wr_act, rd_act, wr_done, rd_start;
   assign wr_act = !(wr_n | cs_n);
   assign rd_act = !(rd_n | cs_n);
   always_comb begin
      next_acc = acc;
      case (acc)
         HPS_ACC_IDLE: begin
            if (rd_act) begin
               next_acc = HPS_ACC_READ;
            end else if (wr_act) begin
               next_acc = HPS_ACC_WRITE;
            end
         end
         HPS_ACC_READ: begin
            if (!rd_act) begin
               next_acc = HPS_ACC_IDLE;
            end
         end
         HPS_ACC_WRITE: begin
            if (!wr_act) begin
               next_acc = HPS_ACC_IDLE;
            end
         end
         default: next_acc = HPS_ACC_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         acc <= HPS_ACC_IDLE;
      end else begin
         acc <= next_acc;
      end
   end
   assign rd_start = (acc == HPS_ACC_IDLE) && rd_act;
   assign wr_done = (acc == HPS_ACC_WRITE) && !wr_act;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // data sampled with the strobe still low; it is settled well before the rise
   hps_byte_t wr_hold;
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_hold <= 8'h00;
      end else if (wr_act) begin
         wr_hold <= dat_s;
      end
   end

   hps_byte_t rx_cfg, rx_irq_cfg, dl_cfg;
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_cfg <= `HPS_RST_RX_CFG;
         rx_irq_cfg <= `HPS_RST_RX_IRQ;
         dl_cfg <= `HPS_RST_DL_CFG;
      end else if (wr_done) begin
         if (hit(addr_lat, `HPS_ADDR_RX_CFG)) rx_cfg <= wr_hold;
         if (hit(addr_lat, `HPS_ADDR_RX_IRQ)) rx_irq_cfg <= wr_hold;
         if (hit(addr_lat, `HPS_ADDR_DL_CFG)) dl_cfg <= wr_hold;
      end
   end
   logic rx_on;
   assign rx_on = rx_cfg[`HPS_BIT_RX_EN] && dl_cfg[`HPS_BIT_DL_RX_ON]
                  && !rx_cfg[`HPS_BIT_RX_TERM];

   // receive fifo
   logic [`HPS_FIFO_AW-1:0] wp, rp;
   logic [`HPS_FIFO_AW:0] cnt;
   logic [`HPS_FIFO_W-1:0] head;
   logic full, empty, push, pop, ovr_ev;
   assign full = cnt[`HPS_FIFO_AW];
   assign empty = (cnt == '0);
   assign push = rx_on && rx_byte_valid_in && !full;
   assign ovr_ev = rx_on && rx_byte_valid_in && full;
   assign pop = rd_start && hit(addr_lat, `HPS_ADDR_RX_DATA) && !empty;
   hps_fifo_mem u_mem (
      .clk_sys_in(clk_sys_in),
      .wr_en_in(push),
      .wr_addr_in(wp),
      .wr_data_in({rx_byte_tag_in, rx_byte_in}),
      .rd_addr_in(rp),
      .rd_data_out(head)
   );
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else if (!rx_on) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         if (push) wp <= wp + 1'b1;
         if (pop) rp <= rp + 1'b1;
         cnt <= cnt + {4'h0, push} - {4'h0, pop};
      end
   end

   // interrupt latches: fill and event share one, overrun has its own
   logic ev_now, thr_hit, last_pop, sts_rd;
   logic fill_lat, ovr_lat, irq_lat;
   assign ev_now = push && (rx_byte_tag_in != HPS_TAG_DATA);
   assign thr_hit = rx_on && (cnt >= {1'b0, rx_irq_cfg[`HPS_MSB_IRQ_THR:`HPS_LSB_IRQ_THR]})
                    && !empty;
   assign last_pop = pop && (cnt == 5'h01);
   assign sts_rd = rd_start && hit(addr_lat, `HPS_ADDR_RX_STATUS);
   assign irq_lat = fill_lat | ovr_lat;
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         fill_lat <= 1'b0;
         ovr_lat <= 1'b0;
      end else if (!rx_on) begin
         fill_lat <= 1'b0;
         ovr_lat <= 1'b0;
      end else begin
         // a new event byte in the clearing cycle keeps the latch set
         if (ev_now || (thr_hit && !last_pop)) begin
            fill_lat <= 1'b1;
         end else if (last_pop) begin
            fill_lat <= 1'b0;
         end
         if (ovr_ev) begin
            ovr_lat <= 1'b1;
         end else if (sts_rd) begin
            ovr_lat <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_link_irq_out <= 1'b0;
      end else begin
         // mask gates the pin only; the latch stays visible in the irq register
         rx_link_irq_out <= (ev_now || ovr_ev || irq_lat) && rx_on
                            && rx_irq_cfg[`HPS_BIT_IRQ_EN];
      end
   end

   // end flag
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_link_end_flag_out <= 1'b0;
      end else if (!rx_on) begin
         rx_link_end_flag_out <= 1'b0;
      end else if (ovr_ev || (pop && head[9:8] != HPS_TAG_DATA)) begin
         rx_link_end_flag_out <= 1'b1;
      end else if (sts_rd) begin
         rx_link_end_flag_out <= 1'b0;
      end
   end

   // read data path
   hps_byte_t rd_mux;
   always_comb begin
      case (1'b1)
         hit(addr_lat, `HPS_ADDR_RX_CFG): rd_mux = rx_cfg;
         hit(addr_lat, `HPS_ADDR_RX_IRQ): rd_mux = {rx_irq_cfg[7], irq_lat, rx_irq_cfg[5:0]};
         hit(addr_lat, `HPS_ADDR_RX_STATUS):
            rd_mux = {ovr_lat, fill_lat, full, empty, tx_link_underrun_out, 3'h0};
         hit(addr_lat, `HPS_ADDR_RX_DATA): rd_mux = empty ? 8'h00 : head[7:0];
         hit(addr_lat, `HPS_ADDR_DL_CFG): rd_mux = dl_cfg;
         default: rd_mux = 8'h00;
      endcase
   end
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         data_out <= 8'h00;
         data_oe_out <= 1'b0;
      end else begin
         if (rd_start) data_out <= rd_mux;
         data_oe_out <= rd_act;
      end
   end

   // transmit request, answer and underrun watchdog
   logic tclk_d, tclk_rise, tx_wr;
   logic [2:0] tper;
   assign tclk_rise = tclk && !tclk_d;
   assign tx_wr = wr_done && hit(addr_lat, `HPS_ADDR_TX_DATA);
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tclk_d <= 1'b0;
         tx_link_data_request_out <= 1'b0;
         tx_data_out <= 8'h00;
         tx_data_valid_out <= 1'b0;
      end else begin
         tclk_d <= tclk;
         tx_data_valid_out <= tx_wr;
         if (tx_wr) begin
            tx_data_out <= wr_hold;
            tx_link_data_request_out <= 1'b0;
         end else if (tx_byte_taken_in) begin
            tx_link_data_request_out <= 1'b1;
         end
      end
   end
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tper <= 3'h0;
         tx_link_underrun_out <= 1'b0;
      end else if (tx_wr) begin
         tper <= 3'h0;
         tx_link_underrun_out <= 1'b0;
      end else if (tx_link_data_request_out && tclk_rise) begin
         if (tper == `HPS_TDL_TIMEOUT_PERIODS - 3'h1) begin
            tx_link_underrun_out <= 1'b1;
         end else begin
            tper <= tper + 3'h1;
         end
      end
   end

   // shared pin: input after reset, request output once configured
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_link_pin_oe_out <= 1'b0;
         tx_link_pin_out <= 1'b1;
         tx_link_serial_in_out <= 1'b1;
      end else begin
         tx_link_pin_oe_out <= dl_cfg[`HPS_BIT_DL_PIN_OUT];
         tx_link_pin_out <= tx_link_data_request_out;
         tx_link_serial_in_out <= pin_s2[16];
      end
   end

   // checks
   sequence s_status_read;
      rd_start && hit(addr_lat, `HPS_ADDR_RX_STATUS);
   endsequence
   sequence s_final_pop;
      pop && cnt == 5'h01 && !ovr_lat && !push;
   endsequence
   a_irq_force_low: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !rx_on |=> !rx_link_irq_out) else $error("irq high while receiver off");
   a_irq_mask: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !rx_irq_cfg[`HPS_BIT_IRQ_EN] |=> !rx_link_irq_out) else $error("masked irq seen");
   a_irq_event: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (ovr_ev && rx_irq_cfg[`HPS_BIT_IRQ_EN]) |=> rx_link_irq_out) else $error("late irq");
   a_ovr_holds: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (ovr_lat && rx_on && !sts_rd) |=> ovr_lat) else $error("overrun irq lost");
   a_empty_clear: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      s_final_pop ##0 !ev_now |=> !fill_lat) else $error("irq not cleared on empty");
   a_eom_clear: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      s_status_read ##0 !ovr_ev ##0 !pop |=> !rx_link_end_flag_out)
      else $error("end flag not cleared");
   a_bus_drive: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      data_oe_out |-> $past(rd_act)) else $error("bus driven without read");
   a_ale_hold: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !$past(ale) |-> $stable(addr_lat)) else $error("address moved while latched");
   a_underrun: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      tx_link_underrun_out && !$past(tx_link_underrun_out) |-> $past(tper) == 3'h3)
      else $error("underrun before four periods");
endmodule

// file: tb/hps_host_model.sv
// microprocessor bus master model for the host port
`timescale 1ns/1ps
module hps_host_model (
   input wire logic clk_in,
   input wire hps_pkg::hps_byte_t rdata_in,
   input wire logic roe_in,
   output logic wr_n_out,
   output logic rd_n_out,
   output logic cs_n_out,
   output logic ale_out,
   output logic [7:0] addr_out,
   output hps_pkg::hps_byte_t wdata_out
);
   import hps_pkg::*;
   initial begin
      wr_n_out = 1'b1;
      rd_n_out = 1'b1;
      cs_n_out = 1'b1;
      ale_out = 1'b1;
      addr_out = 8'h00;
      wdata_out = 8'h00;
   end
   // one access: write when wr is set, otherwise read; v and oe sampled before release
   task automatic acc(input logic wr, input logic [7:0] a, input hps_byte_t d,
                      input logic cs_n, output hps_byte_t v, output logic oe);
      @(posedge clk_in);
      ale_out <= 1'b1;
      addr_out <= a;
      wdata_out <= d;
      cs_n_out <= cs_n;
      @(posedge clk_in);
      ale_out <= 1'b0;
      // a wrong address on the pins must not matter once the latch has closed
      addr_out <= ~a;
      wr_n_out <= ~wr;
      rd_n_out <= wr;
      repeat (5) @(posedge clk_in);
      v = rdata_in;
      oe = roe_in;
      wr_n_out <= 1'b1;
      rd_n_out <= 1'b1;
      // data held until the synchronised rising strobe has been taken
      repeat (4) @(posedge clk_in);
      cs_n_out <= 1'b1;
      wdata_out <= ~d;
      repeat (3) @(posedge clk_in);
   endtask
endmodule

// file: tb/tb.sv
// self-checking testbench of the host port
`timescale 1ns/1ps
`include "hps_regs.svh"
module tb;
   import hps_pkg::*;
   localparam logic [7:0] A_CFG = `HPS_ADDR_RX_CFG, A_IRQ = `HPS_ADDR_RX_IRQ;
   localparam logic [7:0] A_ST = `HPS_ADDR_RX_STATUS, A_DAT = `HPS_ADDR_RX_DATA;
   localparam logic [7:0] A_DL = `HPS_ADDR_DL_CFG, A_TX = `HPS_ADDR_TX_DATA;
   logic clk_sys_in = 1'b0, rstn_in = 1'b0, wr_n, rd_n, cs_n, ale, doe, oe;
   logic rxv = 1'b0, taken = 1'b0, lclk = 1'b0, pin, pin_out, pin_oe;
   logic ser, req, txv, irq, eom, udr;
   logic [7:0] addr;
   hps_byte_t wdata, bus, dout, rxb = 8'h00, txd, v, b;
   hps_tag_t rxt = HPS_TAG_DATA;
   integer seed, n_mismatch = 0, tests_run = 0, cyc = 0, thr, k, n_txv = 0;
   hps_byte_t q[$];
   initial forever #25 clk_sys_in = ~clk_sys_in;
   // bus and shared pin resolved from the port's output enables; the pin has a pull-up
   assign bus = doe ? dout : wdata;
   assign pin = pin_oe ? pin_out : 1'b1;
   hps_host_model i_host (.clk_in(clk_sys_in), .rdata_in(dout), .roe_in(doe),
      .wr_n_out(wr_n), .rd_n_out(rd_n), .cs_n_out(cs_n), .ale_out(ale),
      .addr_out(addr), .wdata_out(wdata));
   hps_host_port i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
      .write_strobe_n_in(wr_n), .read_strobe_n_in(rd_n), .chip_select_n_in(cs_n),
      .ale_in(ale), .addr_in(addr), .data_in(bus), .data_out(dout), .data_oe_out(doe),
      .rx_byte_valid_in(rxv), .rx_byte_in(rxb), .rx_byte_tag_in(rxt),
      .tx_byte_taken_in(taken), .tx_link_clock_in(lclk), .tx_link_serial_in_in(pin),
      .tx_link_serial_in_out(ser), .tx_link_data_request_out(req),
      .tx_link_pin_out(pin_out), .tx_link_pin_oe_out(pin_oe), .tx_data_out(txd),
      .tx_data_valid_out(txv), .rx_link_irq_out(irq), .rx_link_end_flag_out(eom),
      .tx_link_underrun_out(udr));
   function automatic hps_byte_t irq_word(input logic en, input integer t);
      return {en, 3'h0, 4'(t)};
   endfunction
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input hps_byte_t d);
      i_host.acc(1'b1, a, d, 1'b0, v, oe);
   endtask
   task automatic rd(input logic [7:0] a);
      i_host.acc(1'b0, a, 8'h00, 1'b0, v, oe);
   endtask
   task automatic push(input hps_byte_t d, input hps_tag_t t);
      @(posedge clk_sys_in);
      rxv <= 1'b1;
      rxb <= d;
      rxt <= t;
      @(posedge clk_sys_in);
      rxv <= 1'b0;
      // one edge more than the output needs, so checks never race the edge that sets it
      repeat (3) @(posedge clk_sys_in);
   endtask
   task automatic cfg(input hps_byte_t irqv);
      wr(A_DL, 8'h01);
      wr(A_CFG, 8'h01);
      wr(A_IRQ, irqv);
   endtask
   // link clock only moves while a request waits; it stands low otherwise
   task automatic link(input integer n);
      repeat (n) begin
         @(posedge clk_sys_in) lclk <= 1'b1;
         repeat (6) @(posedge clk_sys_in);
         lclk <= 1'b0;
         repeat (6) @(posedge clk_sys_in);
      end
      repeat (4) @(posedge clk_sys_in);
   endtask
   always @(posedge clk_sys_in) begin
      cyc++;
      if (txv) n_txv++;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   initial begin
      seed = 32'h1364;
      repeat (2) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      chk({irq, eom, udr, doe, pin_oe}, 8'h00);
      chk({pin, ser}, 8'h03);
      wr(8'h3c, 8'h5a);
      rd(8'h3c);
      chk(v, 8'h00);
      cfg(irq_word(1'b1, 1));
      i_host.acc(1'b1, A_IRQ, 8'h05, 1'b1, v, oe);
      rd(A_IRQ);
      chk(v & 8'h8f, 8'h81);
      chk(oe, 1'b1);
      i_host.acc(1'b0, A_IRQ, 8'h00, 1'b1, v, oe);
      chk(oe, 1'b0);
      thr = 2 + ($random(seed) & 3);
      wr(A_IRQ, irq_word(1'b1, thr));
      for (k = 0; k < thr; k++) begin
         b = 8'($random(seed));
         q.push_back(b);
         chk(irq, 1'b0);
         push(b, HPS_TAG_DATA);
      end
      chk(irq, 1'b1);
      for (k = 0; k < thr; k++) begin
         rd(A_DAT);
         chk(v, q[k]);
         chk(irq, 8'(k < thr - 1));
      end
      for (k = 1; k < 4; k++) begin
         push(8'($random(seed)), hps_tag_t'(k));
         chk({irq, eom}, 8'h02);
         rd(A_DAT);
         chk(eom, 1'b1);
         rd(A_ST);
         chk(eom, 1'b0);
      end
      for (k = 0; k < 17; k++) push(8'($random(seed)), HPS_TAG_DATA);
      chk({irq, eom}, 8'h03);
      for (k = 0; k < 16; k++) rd(A_DAT);
      chk(irq, 1'b1);
      rd(A_ST);
      chk(v[7], 1'b1);
      chk({irq, eom}, 8'h00);
      wr(A_IRQ, irq_word(1'b0, 1));
      push(8'($random(seed)), HPS_TAG_DATA);
      chk(irq, 1'b0);
      rd(A_IRQ);
      chk(v[6], 1'b1);
      wr(A_IRQ, irq_word(1'b1, 1));
      chk(irq, 1'b1);
      rd(A_DAT);
      @(posedge clk_sys_in) taken <= 1'b1;
      @(posedge clk_sys_in) taken <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      chk(req, 1'b1);
      link(3);
      chk(udr, 1'b0);
      link(1);
      chk(udr, 1'b1);
      rd(A_ST);
      chk(v[3], 1'b1);
      b = 8'($random(seed));
      wr(A_TX, b);
      chk({req, udr}, 8'h00);
      chk(txd, b);
      chk(8'(n_txv), 8'h01);
      // shared pin turned to an output shows the idle request level, not the pull-up
      wr(A_DL, 8'h02);
      repeat (2) @(posedge clk_sys_in);
      chk({pin_oe, pin, ser}, 8'h04);
      for (k = 0; k < 3; k++) begin
         cfg(irq_word(1'b1, 1));
         push(8'($random(seed)), HPS_TAG_DATA);
         chk(irq, 1'b1);
         if (k == 0) wr(A_CFG, 8'h00);
         else if (k == 1) wr(A_DL, 8'h00);
         else wr(A_CFG, 8'h03);
         chk(irq, 1'b0);
      end
      cfg(irq_word(1'b1, 1));
      push(8'($random(seed)), HPS_TAG_EOM);
      chk(irq, 1'b1);
      @(posedge clk_sys_in) rstn_in <= 1'b0;
      #1;
      chk({irq, pin_oe, doe}, 8'h00);
      report_and_stop();
   end
endmodule
